// *** shared/audio_tx_pkg.sv ***
// Constants for the serial audio transmitter.
// Assumes a 16-bit word-access internal CPU bus, 12-bit byte address.
package audio_tx_pkg;
  // Register word addresses (bits 11:2 compared for FIFO ports)
  localparam logic [11:0] RIGHT_PORT_ADDR = 12'h800;
  localparam logic [11:0] LEFT_PORT_ADDR  = 12'h808;
  localparam logic [11:0] CTRL_ADDR       = 12'h80E;
  // Control field positions
  localparam int TXE_BIT   = 7;
  localparam int FMT_BIT   = 6;
  localparam int BUSY_BIT  = 5;
  localparam int DIR_BIT   = 4;
  localparam int LEN_BIT   = 3;
  localparam int RATE_HI   = 2;
  localparam int RATE_LO   = 1;
  localparam int WCK_BIT   = 0;
  localparam int SYSCK_BIT = 8;
  localparam int CLKE_BIT  = 12;
  localparam int FSEL_BIT  = 13;
  localparam int EDGE_BIT  = 14;
  localparam int WLVL_BIT  = 15;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // FIFO shapes, one entry is one 16-bit bus word
  localparam int DATA_W      = 16;
  localparam int RIGHT_DEPTH = 16;
  localparam int LEFT_DEPTH  = 8;
  localparam int RCNT_W      = 5;
  localparam int LCNT_W      = 4;
  // Bit timing
  localparam logic [4:0] BITS_8  = 5'd8;
  localparam logic [4:0] BITS_16 = 5'd16;
  localparam logic [4:0] BIT_PERIOD_BASE = 5'd2;
endpackage : audio_tx_pkg

// *** rtl/serial_audio_transmitter.sv ***
// Serial audio transmitter: word FIFOs and master-only serial output.
// Assumes a word-access CPU bus on clk_i and asynchronous word-select
// sources that are synchronised here.
//
// Functional notes
// [RULE1] A 32-byte transmit FIFO; empty interrupt asks software to refill.
// [RULE2] Interrupt fires when last entry moves to shifter; FIFO then writable.
// [RULE3] Writing transmit_enable 1 starts sending, writing 0 stops it.
// [RULE4] Stereo mode repeats right then left words automatically.
// [RULE5] Software clears transmit_enable in the handler after busy falls.
// [RULE6] Clearing transmit_enable mid-word halts output immediately.
// [RULE7] Stereo mode: 16-byte right and left FIFOs, even byte counts; code keeps the right FIFO at 32 bytes.
// [RULE8] Mono select 1 takes samples from the right FIFO only.
// [RULE9] In mono the other slot carries all-zero data.
// [RULE10] Software writes FIFO ports with word or long-word accesses only.
// [RULE11] Right port answers 0800H-0803H, left port 0808H-080BH.
// [RULE12] Plain serial mode clears transmit_enable when busy falls.
// [RULE13] Plain serial mode uses one 32-byte FIFO, even counts 2 to 32.
// [RULE14] Plain serial mode: after all bytes, busy and enable drop alone.
// [RULE15] Plain serial mode latches written count when enable is set.
// [RULE16] Software reloads the FIFO before setting enable again.
// [RULE17] Plain serial mode accepts data only at the right port.
// [RULE18] Transmit-only master: drives clock and data, no receive path.
// [RULE19] Registers sit on the 16-bit internal CPU bus.
// [RULE20] Word select from low-speed clock divided by four or timer output.
// [RULE21] Data changes on rising or falling serial clock edge as selected.
// [RULE22] MSB-first or LSB-first, 8 or 16 bit words as configured.
// [RULE23] Serial clock rate is system clock divided by 1, 2, 4 or 8; code divides clk_i by 2, 4, 8 or 16.
// [RULE24] Word-select polarity bit picks which level marks left.
`timescale 1ns/1ns
`default_nettype none

module audio_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and control
  input  wire logic                           clk_i,
  input  wire logic                           srst_i,
  input  wire logic                           ce_i,
  // Fill side
  input  wire logic                           wr_valid_i,
  output logic                                wr_ready_o,
  input  wire logic [WIDTH-1:0]               wr_data_i,
  // Drain side
  output logic                                rd_valid_o,
  input  wire logic                           rd_ready_i,
  output logic      [WIDTH-1:0]               rd_data_o,
  output logic      [$clog2(DEPTH+1)-1:0]     count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [CW-1:0]    cnt_r;
  logic             do_wr;
  logic             do_rd;

  assign wr_ready_o = (cnt_r != CW'(DEPTH));
  assign rd_valid_o = (cnt_r != '0);
  assign rd_data_o  = mem_r[rptr_r];
  assign count_o    = cnt_r;
  assign do_wr      = wr_valid_i && wr_ready_o;
  assign do_rd      = rd_ready_i && rd_valid_o;

  always_ff @(posedge clk_i) begin
    if (ce_i && do_wr) begin
      mem_r[wptr_r] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end else if (ce_i) begin
      if (do_wr) begin
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      end
      if (do_rd) begin
        rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : audio_word_fifo

module serial_audio_transmitter
  import audio_tx_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  // CPU bus
  input  wire logic [11:0] bus_addr_i,
  input  wire logic [15:0] bus_wdata_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  output logic             bus_wready_o,
  output logic      [15:0] bus_rdata_o,
  // Word-select sources
  input  wire logic        low_speed_clock_i,
  input  wire logic        timer_channel_output_i,
  // Serial pins and event
  output logic             serial_clock_out_o,
  output logic             serial_data_out_o,
  output logic             word_select_out_o,
  output logic             fifo_empty_irq_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SHIFT, ST_PAD} tx_state_e;

  tx_state_e           state_r;
  logic                txe_r, fmt_r, dir_r, len16_r, wck_r, sysck_r;
  logic                wlvl_r, edge_r, fsel_r, clke_r;
  logic [1:0]          rate_r;
  logic [15:0]         shift_r;
  logic [4:0]          bits_r;
  logic [3:0]          div_r;
  logic [RCNT_W-1:0]   words_r;
  logic                sck_r, sdo_r, irq_r;
  logic [15:0]         rdata_r;
  logic [2:0]          fs_sync_r, tm_sync_r;
  logic                fs_clean_r, tm_clean_r, fs_prev_r;
  logic [1:0]          fs_div_r;
  logic                ws_prev_r;
  logic                ctrl_wr, txe_set, stop, txe_hw_clr;
  logic                r_sel, l_sel, r_wr, l_wr;
  logic                r_valid, l_valid, r_rdy, l_rdy;
  logic [DATA_W-1:0]   r_data, l_data;
  logic [RCNT_W-1:0]   r_cnt;
  logic [LCNT_W-1:0]   l_cnt;
  logic                ws_lvl, ws_edge, left_ph, busy;
  logic                slot_go, sio_start, sio_next, word_end, tick_end;
  logic                load, pop_r, pop_l;
  logic [15:0]         load_word;
  logic [3:0]          full_m1, half;

  // Address decode, words only
  assign r_sel   = (bus_addr_i[11:2] == RIGHT_PORT_ADDR[11:2]); // [RULE11]
  assign l_sel   = (bus_addr_i[11:2] == LEFT_PORT_ADDR[11:2]);  // [RULE11]
  assign ctrl_wr = bus_wr_i && (bus_addr_i == CTRL_ADDR); // [RULE19]
  assign r_wr    = bus_wr_i && r_sel;
  assign l_wr    = bus_wr_i && l_sel && !fmt_r; // [RULE17]
  assign txe_set = ctrl_wr && bus_wdata_i[TXE_BIT] && !txe_r; // [RULE3]
  assign stop    = ctrl_wr && !bus_wdata_i[TXE_BIT]; // [RULE6]
  assign bus_wready_o = r_sel ? r_rdy : (l_wr ? l_rdy : 1'b1);

  // Right FIFO serves both modes, left only stereo
  audio_word_fifo #(.WIDTH(DATA_W), .DEPTH(RIGHT_DEPTH)) u_right ( // [RULE13]
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .wr_valid_i (r_wr),
    .wr_ready_o (r_rdy),
    .wr_data_i  (bus_wdata_i),
    .rd_valid_o (r_valid),
    .rd_ready_i (pop_r),
    .rd_data_o  (r_data),
    .count_o    (r_cnt)
  );
  audio_word_fifo #(.WIDTH(DATA_W), .DEPTH(LEFT_DEPTH)) u_left ( // [RULE7]
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .wr_valid_i (l_wr),
    .wr_ready_o (l_rdy),
    .wr_data_i  (bus_wdata_i),
    .rd_valid_o (l_valid),
    .rd_ready_i (pop_l),
    .rd_data_o  (l_data),
    .count_o    (l_cnt)
  );

  // Control register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      {wlvl_r, edge_r, fsel_r, clke_r} <= CTRL_RESET[15:12];
      {txe_r, fmt_r, dir_r, len16_r}   <= CTRL_RESET[7:4];
      {rate_r, wck_r, sysck_r}         <= {CTRL_RESET[2:0], CTRL_RESET[8]};
    end else if (ce_i) begin
      if (ctrl_wr) begin
        txe_r   <= bus_wdata_i[TXE_BIT]; // [RULE3]
        fmt_r   <= bus_wdata_i[FMT_BIT];
        dir_r   <= bus_wdata_i[DIR_BIT];
        len16_r <= bus_wdata_i[LEN_BIT];
        rate_r  <= bus_wdata_i[RATE_HI:RATE_LO];
        wck_r   <= bus_wdata_i[WCK_BIT];
        sysck_r <= bus_wdata_i[SYSCK_BIT];
        clke_r  <= bus_wdata_i[CLKE_BIT];
        fsel_r  <= bus_wdata_i[FSEL_BIT];
        edge_r  <= bus_wdata_i[EDGE_BIT];
        wlvl_r  <= bus_wdata_i[WLVL_BIT];
      end else if (txe_hw_clr) begin
        txe_r <= 1'b0; // [RULE12] [RULE14]
      end
    end
  end

  // Register read, status shows busy
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_r <= 16'h0000;
    end else if (ce_i) begin
      rdata_r <= 16'h0000;
      if (bus_rd_i && bus_addr_i == CTRL_ADDR) begin
        rdata_r <= {wlvl_r, edge_r, fsel_r, clke_r, 3'b000, sysck_r,
                    txe_r, fmt_r, busy, dir_r, len16_r, rate_r, wck_r};
      end
    end
  end
  assign bus_rdata_o = rdata_r;

  // Word-select source sync and fs/4 divider
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fs_sync_r  <= 3'b000;
      tm_sync_r  <= 3'b000;
      fs_clean_r <= 1'b0;
      tm_clean_r <= 1'b0;
      fs_prev_r  <= 1'b0;
      fs_div_r   <= 2'b00;
      ws_prev_r  <= 1'b0;
    end else if (ce_i) begin
      fs_sync_r <= {fs_sync_r[1:0], low_speed_clock_i};
      tm_sync_r <= {tm_sync_r[1:0], timer_channel_output_i};
      if (fs_sync_r[1] == fs_sync_r[2]) begin
        fs_clean_r <= fs_sync_r[2];
      end
      if (tm_sync_r[1] == tm_sync_r[2]) begin
        tm_clean_r <= tm_sync_r[2];
      end
      fs_prev_r <= fs_clean_r;
      if (fs_clean_r && !fs_prev_r) begin
        fs_div_r <= fs_div_r + 2'd1; // [RULE20]
      end
      ws_prev_r <= ws_lvl;
    end
  end

  assign ws_lvl  = wck_r ? tm_clean_r : fs_div_r[1]; // [RULE20]
  assign ws_edge = (ws_lvl != ws_prev_r);
  assign left_ph = (ws_lvl == wlvl_r); // [RULE24]
  assign busy    = (state_r == ST_SHIFT);

  // Bit timing
  assign full_m1  = 4'((BIT_PERIOD_BASE << rate_r) - 5'd1); // [RULE23]
  assign half     = 4'(5'd1 << rate_r);
  assign tick_end = (div_r == full_m1);
  assign word_end = busy && tick_end && (bits_r == 5'd1);

  // Word scheduling
  assign slot_go   = !fmt_r && txe_r && ws_edge && (state_r != ST_IDLE)
                     && (state_r != ST_WAIT || !left_ph); // [RULE4]
  assign sio_start = fmt_r && txe_set && r_valid && (state_r == ST_IDLE);
  assign sio_next  = fmt_r && word_end && (words_r > RCNT_W'(1));
  assign txe_hw_clr = fmt_r && txe_r && (state_r == ST_IDLE); // [RULE12]

  always_comb begin
    load      = 1'b0;
    pop_r     = 1'b0;
    pop_l     = 1'b0;
    load_word = 16'h0000;
    if (slot_go) begin
      load = 1'b1;
      if (!left_ph) begin
        pop_r     = r_valid;
        load_word = r_valid ? r_data : 16'h0000;
      end else if (!fsel_r) begin
        pop_l     = l_valid;
        load_word = l_valid ? l_data : 16'h0000;
      end else begin
        load_word = 16'h0000; // [RULE8] [RULE9]
      end
    end else if (sio_start || sio_next) begin
      load      = 1'b1;
      pop_r     = r_valid;
      load_word = r_data;
    end
  end

  // Transmit state machine
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= ST_IDLE;
      shift_r <= 16'h0000;
      bits_r  <= 5'd0;
      div_r   <= 4'd0;
      words_r <= '0;
    end else if (ce_i) begin
      if (stop) begin
        state_r <= ST_IDLE; // [RULE6]
        div_r   <= 4'd0;
      end else if (load) begin
        state_r <= ST_SHIFT;
        div_r   <= 4'd0;
        bits_r  <= len16_r ? BITS_16 : BITS_8; // [RULE22]
        shift_r <= (len16_r || dir_r) ? load_word
                                      : {load_word[7:0], 8'h00};
        if (sio_start) begin
          words_r <= r_cnt; // [RULE15]
        end else if (sio_next) begin
          words_r <= words_r - 1'b1;
        end
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (txe_set && !fmt_r) begin
              state_r <= ST_WAIT;
            end
          end
          ST_SHIFT: begin
            if (tick_end) begin
              div_r  <= 4'd0;
              bits_r <= bits_r - 5'd1;
              shift_r <= dir_r ? (shift_r >> 1) : (shift_r << 1); // [RULE22]
              if (bits_r == 5'd1) begin
                state_r <= fmt_r ? ST_IDLE : ST_PAD; // [RULE14]
              end
            end else begin
              div_r <= div_r + 4'd1;
            end
          end
          ST_WAIT, ST_PAD: begin
            state_r <= state_r;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Pin and event registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sck_r <= 1'b0;
      sdo_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce_i) begin
      sck_r <= busy && !stop && (edge_r ^ (div_r >= half)); // [RULE21] [RULE18]
      sdo_r <= busy && !stop && (dir_r ? shift_r[0] : shift_r[15]); // [RULE6]
      irq_r <= (pop_r && r_cnt == RCNT_W'(1) && (fmt_r || fsel_r || !l_valid))
            || (pop_l && l_cnt == LCNT_W'(1) && !r_valid); // [RULE1] [RULE2]
    end
  end

  assign serial_clock_out_o = sck_r;
  assign serial_data_out_o  = sdo_r;
  assign word_select_out_o  = !fmt_r && txe_r && ws_lvl;
  assign fifo_empty_irq_o   = irq_r;
endmodule : serial_audio_transmitter
`default_nettype wire

// *** sim/serial_audio_transmitter_sva.sv ***
// Checker for the serial audio transmitter top-level ports.
// Assumes ce_i stays high while serial transfers run.
`timescale 1ns/1ns
`default_nettype none
module serial_audio_transmitter_sva
  import audio_tx_pkg::*;
(
  // Clock and bus
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        ce_i,
  input wire logic [11:0] bus_addr_i,
  input wire logic [15:0] bus_wdata_i,
  input wire logic        bus_wr_i,
  input wire logic        bus_rd_i,
  input wire logic [15:0] bus_rdata_o,
  // Serial pins and event
  input wire logic        serial_clock_out_o,
  input wire logic        serial_data_out_o,
  input wire logic        word_select_out_o,
  input wire logic        fifo_empty_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic       wr_ctl;
  logic       rd_ctl;
  logic       wr_ctl_q;
  logic       fmt_r;
  logic       edge_r;
  logic [1:0] rate_r;
  assign wr_ctl = ce_i && bus_wr_i && (bus_addr_i == CTRL_ADDR);
  assign rd_ctl = ce_i && bus_rd_i && (bus_addr_i == CTRL_ADDR);
  // Shadow of mode fields
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      {wr_ctl_q, fmt_r, edge_r, rate_r} <= 5'h00;
    end else begin
      wr_ctl_q <= wr_ctl;
      if (wr_ctl) begin
        fmt_r  <= bus_wdata_i[FMT_BIT];
        edge_r <= bus_wdata_i[EDGE_BIT];
        rate_r <= bus_wdata_i[RATE_HI:RATE_LO];
      end
    end
  end
  a_irq_one_pulse: assert property (fifo_empty_irq_o |=> !fifo_empty_irq_o)
    else $error("empty event longer than one cycle");
  a_abort_goes_quiet: assert property (wr_ctl && !bus_wdata_i[TXE_BIT] |=>
    !serial_clock_out_o && !serial_data_out_o && !word_select_out_o)
    else $error("output still active after stop");
  a_stop_reads_idle: assert property (wr_ctl && !bus_wdata_i[TXE_BIT]
    ##2 rd_ctl |=> !bus_rdata_o[BUSY_BIT] && !bus_rdata_o[TXE_BIT])
    else $error("busy or enable set after stop");
  a_rdata_only_ctrl: assert property (ce_i && !rd_ctl |=>
    bus_rdata_o == 16'h0000)
    else $error("read data without control read");
  a_fields_read_back: assert property (wr_ctl ##1 !wr_ctl ##1 rd_ctl |=>
    (bus_rdata_o & 16'hF15F) == ($past(bus_wdata_i, 3) & 16'hF15F))
    else $error("control fields not read back");
  a_ws_serial_low: assert property (fmt_r |-> !word_select_out_o)
    else $error("word select active in serial mode");
  a_data_mid_stable: assert property (!wr_ctl_q && (edge_r ?
    $fell(serial_clock_out_o) : $rose(serial_clock_out_o))
    |-> $stable(serial_data_out_o))
    else $error("data changed on the sampling edge");
  a_rate0_half_bit: assert property (rate_r == 2'h0 &&
    $rose(serial_clock_out_o) |=> !serial_clock_out_o)
    else $error("serial clock high too long");
  c_irq: cover property (fifo_empty_irq_o);
  c_abort: cover property (wr_ctl && !bus_wdata_i[TXE_BIT] && serial_clock_out_o);
  c_ws: cover property ($rose(word_select_out_o));
endmodule : serial_audio_transmitter_sva

bind serial_audio_transmitter serial_audio_transmitter_sva sva_i (
  .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .bus_addr_i(bus_addr_i),
  .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
  .bus_rdata_o(bus_rdata_o), .serial_clock_out_o(serial_clock_out_o),
  .serial_data_out_o(serial_data_out_o),
  .word_select_out_o(word_select_out_o), .fifo_empty_irq_o(fifo_empty_irq_o)
);
`default_nettype wire

// *** sim/audio_sink_model.sv ***
// Far-side sink: collects serial words with their word-select level.
// Assumes data sampled on the rising serial clock, MSB first, 16 bits.
`timescale 1ns/1ns
`default_nettype none
module audio_sink_model (
  // Serial pins from the transmitter
  input wire logic sck_i,
  input wire logic sdo_i,
  input wire logic ws_i
);
  logic [16:0] words[$];
  logic [15:0] shift_r = 16'h0000;
  int          n = 0;
  // Receive only, nothing driven back
  always @(posedge sck_i) begin
    shift_r = {shift_r[14:0], sdo_i};
    n = n + 1;
    if (n == 16) begin
      words.push_back({ws_i, shift_r});
      n = 0;
    end
  end
endmodule : audio_sink_model
`default_nettype wire

// *** sim/tb_serial_audio_transmitter.sv ***
// Self-checking bench for the serial audio transmitter.
// Assumes the bound checker and a sink model on the serial pins.
`timescale 1ns/1ns
`default_nettype none
module tb_serial_audio_transmitter
  import audio_tx_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic [11:0] bus_addr_i = 12'h000;
  logic [15:0] bus_wdata_i = 16'h0000;
  logic        bus_wr_i = 1'b0;
  logic        bus_rd_i = 1'b0;
  logic        low_speed_clock_i = 1'b0;
  logic        timer_channel_output_i = 1'b0;
  logic        bus_wready_o;
  logic [15:0] bus_rdata_o;
  logic        sck, sdo, ws, irq;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always #203 low_speed_clock_i = ~low_speed_clock_i;
  serial_audio_transmitter serial_audio_transmitter_i (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_wready_o(bus_wready_o), .bus_rdata_o(bus_rdata_o),
    .low_speed_clock_i(low_speed_clock_i),
    .timer_channel_output_i(timer_channel_output_i),
    .serial_clock_out_o(sck), .serial_data_out_o(sdo),
    .word_select_out_o(ws), .fifo_empty_irq_o(irq));
  audio_sink_model sink_i (.sck_i(sck), .sdo_i(sdo), .ws_i(ws));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    output logic rdy);
    @(posedge clk_i);
    #1;
    bus_addr_i = a;
    bus_wdata_i = d;
    bus_wr_i = 1'b1;
    #1 rdy = bus_wready_o;
    @(posedge clk_i);
    #1 bus_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk_i);
    #1;
    bus_addr_i = a;
    bus_rd_i = 1'b1;
    @(posedge clk_i);
    #1 bus_rd_i = 1'b0;
    d = bus_rdata_o;
  endtask : rd
  task automatic wait_idle(output logic [15:0] c);
    for (int i = 0; i < 300; i++) begin
      rd(CTRL_ADDR, c);
      if (c[BUSY_BIT] === 1'b0) break;
    end
  endtask : wait_idle
  task automatic wait_irq(input int lim);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(posedge clk_i);
      seen = (irq === 1'b1);
    end
    chk({16'h0000, seen}, 17'h00001);
  endtask : wait_irq
  task automatic t_reset;
    logic [15:0] d;
    rd(CTRL_ADDR, d);
    chk({1'b0, d}, {1'b0, CTRL_RESET});
    rd(12'h804, d);
    chk({1'b0, d}, 17'h00000);
  endtask : t_reset
  task automatic t_serial;
    logic [15:0] c;
    logic        r;
    wr(CTRL_ADDR, 16'h0048, r);
    wr(RIGHT_PORT_ADDR, 16'hA5C3, r);
    wr(12'h808, 16'h1111, r);
    wr(12'h803, 16'h0F96, r);
    sink_i.words.delete();
    wr(CTRL_ADDR, 16'h00C8, r);
    wait_irq(100);
    wait_idle(c);
    rd(CTRL_ADDR, c);
    chk({1'b0, c}, 17'h00048);
    chk(17'(sink_i.words.size()), 17'h00002);
    chk(sink_i.words[0], 17'h0A5C3);
    chk(sink_i.words[1], 17'h00F96);
    sink_i.words.delete();
    wr(RIGHT_PORT_ADDR, 16'h1234, r);
    wr(CTRL_ADDR, 16'h00D8, r);
    wait_idle(c);
    chk(sink_i.words[0], 17'h02C48);
  endtask : t_serial
  task automatic t_mono;
    logic [15:0] c;
    logic        r;
    wr(CTRL_ADDR, 16'h2008, r);
    wr(RIGHT_PORT_ADDR, 16'hC0DE, r);
    sink_i.words.delete();
    wr(CTRL_ADDR, 16'h2088, r);
    wait_irq(400);
    for (int i = 0; i < 400 && sink_i.words.size() < 2; i++) begin
      @(posedge clk_i);
    end
    wait_idle(c);
    wr(CTRL_ADDR, 16'h2008, r);
    chk(sink_i.words[0], 17'h1C0DE);
    chk(sink_i.words[1], 17'h00000);
  endtask : t_mono
  task automatic t_full;
    logic [15:0] d;
    logic        r;
    wr(CTRL_ADDR, 16'h0048, r);
    for (int i = 0; i < 16; i++) begin
      wr(RIGHT_PORT_ADDR, 16'h8001 + 16'(i), r);
      chk({16'h0000, r}, 17'h00001);
    end
    wr(RIGHT_PORT_ADDR, 16'hFFFF, r);
    chk({16'h0000, r}, 17'h00000);
    wr(CTRL_ADDR, 16'h00C8, r);
    repeat (5) @(posedge clk_i);
    wr(CTRL_ADDR, 16'h0048, r);
    rd(CTRL_ADDR, d);
    chk({1'b0, d}, 17'h00048);
  endtask : t_full
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1 srst_i = 1'b0;
    t_reset();
    t_serial();
    t_mono();
    t_full();
    end_of_test();
  end
endmodule : tb_serial_audio_transmitter
`default_nettype wire
